// ---- design/lt_consts.vh ----
/*
 * register indices, field positions, reset values and timing counts of the
 * long timekeeper. assumes it is included by the timekeeper module only.
 */
// What this block does
// R1 - a 32-bit count value advances on each rising edge of the slow clock
// R2 - slow clock is either the 1.024kHz or the 1Hz crystal-derived input
// R3 - the tick after count equals match value raises match request and event
// R4 - the tick after count equals cycle limit raises wrap request, count returns to zero
// R5 - events come every third occurrence at limit zero, every second at one
// R6 - enable bit 0 takes effect half a slow clock cycle after the write; the code applies it on the next falling slow edge
// R7 - counting needs enable set and a nonzero cycle limit
// R8 - snapshot request bit 4 copies the count over, cleared by hardware when done
// R9 - the snapshot is readable eight bus clock cycles after the request
// R10 - sync pending bit 0 is high while control or count writes transfer
// R11 - a written count value takes effect within twelve bus clock cycles
// R12 - count writes are ignored while sync pending is set
// R13 - flags and wake-up are suppressed for two slow ticks after a count load
// R14 - two-bit level fields enable match and wrap interrupts and pick priority
// R15 - match flag bit 1 sets after a match, cleared by vector or writing one
// R16 - wrap flag bit 0 sets after a wrap, cleared by vector or writing one
// R17 - counter keeps running in sleep and can wake the device
// R18 - software writes zero to all reserved bits
// R19 - cycle limit writable only while disabled and no sync is pending
// R20 - a match value above the cycle limit never gives match requests or events
// R21 - count value sits in four byte registers, top byte at index 0x07
// R22 - count reads return the latest snapshot, not the live count
// R23 - device reset clears control, sync, level, flag and count bits
`ifndef LT_CONSTS_VH
`define LT_CONSTS_VH

`define LT_IDX_CTRL 5'h00
`define LT_IDX_SYNC 5'h01
`define LT_IDX_LEVEL 5'h02
`define LT_IDX_FLAGS 5'h03
`define LT_IDX_COUNT_BYTE_LOW 5'h04
`define LT_IDX_COUNT_TOP_BYTE 5'h07
`define LT_IDX_LIM0 5'h08
`define LT_IDX_LIM3 5'h0B
`define LT_IDX_CMP0 5'h0C
`define LT_IDX_CMP3 5'h0F
`define LT_IDX_CLKSEL 5'h10

`define LT_BIT_ENABLE 0
`define LT_BIT_SNAP 4
`define LT_BIT_PENDING 0
`define LT_BIT_WRAP 0
`define LT_BIT_MATCH 1
`define LT_BIT_CLKSEL 0

`define LT_RST_BYTE 8'h00
`define LT_RST_WORD 32'h00000000

`define LT_CNT_SYNC_CYC 4'h4
`define LT_SNAP_CYC 4'h8
`define LT_SUPPRESS_TICKS 2'h2

`define LT_RESP_OKAY 2'h0
`define LT_RESP_SLVERR 2'h2

`endif

// ---- design/lt_timekeeper.v ----
/*
 * long timekeeper: 32-bit slow-clock counter with match and wrap flags,
 * events, wake-up and an axi4-lite register slave.
 * assumes aclk at 250 MHz, the two slow clock pins asynchronous to it,
 * and interrupt acknowledge inputs synchronous to aclk.
 */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "lt_consts.vh"

module lt_timekeeper #(
    parameter ADDR_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire slow_clk_khz,
    input wire slow_clk_hz,
    input wire match_irq_ack,
    input wire wrap_irq_ack,
    output reg match_irq_req,
    output reg wrap_irq_req,
    output reg [1:0] match_irq_level,
    output reg [1:0] wrap_irq_level,
    output reg match_event,
    output reg wrap_event,
    output reg wake_req
);

    // index of a mapped, word-aligned register or all ones
    function [5:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            if (addr[1:0] == 2'b00 && addr[ADDR_W-1:2] <= {{(ADDR_W-7){1'b0}}, `LT_IDX_CLKSEL}) begin
                reg_index = {1'b0, addr[6:2]};
            end else begin
                reg_index = 6'h3F;
            end
        end
    endfunction

    // events are thinned when the limit is too small to cross domains cleanly
    function [1:0] event_modulus;
        input [31:0] limit;
        begin
            if (limit == 32'h00000000) begin
                event_modulus = 2'h3;
            end else if (limit == 32'h00000001) begin
                event_modulus = 2'h2;
            end else begin
                event_modulus = 2'h1;
            end
        end
    endfunction

    // byte write decode for one mapped register
    function wr_hit;
        input [5:0] idx;
        input [4:0] target;
        begin
            wr_hit = (idx != 6'h3F) && (idx[4:0] == target);
        end
    endfunction

    // byte write decode for a four-register group, base on a four-aligned index
    function in_group;
        input [5:0] idx;
        input [4:0] base;
        begin
            in_group = (idx[5:2] == {1'b0, base[4:2]});
        end
    endfunction

    reg khz_s1_reg, khz_s2_reg, hz_s1_reg, hz_s2_reg;
    reg slow_prev_reg;
    reg clksel_reg;
    reg enable_sw_reg;
    reg enable_run_reg;
    reg ctrl_busy_reg;
    reg cnt_busy_reg;
    reg [3:0] cnt_timer_reg;
    reg snap_req_reg;
    reg [3:0] snap_timer_reg;
    reg [31:0] count_value_reg;
    reg [31:0] count_wbuf_reg;
    reg [31:0] snapshot_reg;
    reg [31:0] cycle_limit_reg;
    reg [31:0] match_value_reg;
    reg [1:0] suppress_reg;
    reg match_flag_reg;
    reg wrap_flag_reg;
    reg [1:0] match_evdiv_reg;
    reg [1:0] wrap_evdiv_reg;
    reg aw_got_reg, w_got_reg;
    reg [ADDR_W-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    wire slow_now = clksel_reg ? hz_s2_reg : khz_s2_reg;
    wire slow_rise = slow_now & ~slow_prev_reg;
    wire slow_fall = ~slow_now & slow_prev_reg;
    wire sync_pending_flag = ctrl_busy_reg | cnt_busy_reg;
    wire running = enable_run_reg && (cycle_limit_reg != `LT_RST_WORD);
    // a tick that meets a count load is dropped, so no flag is raised from the stale count
    wire cnt_load = cnt_busy_reg && (cnt_timer_reg == 4'h1);
    wire tick = slow_rise && running && !cnt_load;
    wire wrap_hit = tick && (count_value_reg == cycle_limit_reg);
    wire match_hit = tick && (count_value_reg == match_value_reg) && (match_value_reg <= cycle_limit_reg);
    wire quiet = (suppress_reg != 2'h0);
    wire match_set = match_hit && !quiet;
    wire wrap_set = wrap_hit && !quiet;
    wire [1:0] ev_mod = event_modulus(cycle_limit_reg);

    wire wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire [5:0] wr_idx = reg_index(awaddr_reg);
    wire wr_byte = wr_do && wstrb_reg[0];
    wire [7:0] wb = wdata_reg[7:0];
    wire [5:0] rd_idx = reg_index(s_axi_araddr);

    reg [7:0] rd_byte;
    always @* begin
        case (rd_idx[4:0])
            `LT_IDX_CTRL: rd_byte = {7'h00, enable_sw_reg};
            `LT_IDX_SYNC: rd_byte = {3'h0, snap_req_reg, 3'h0, sync_pending_flag}; // [R10]
            `LT_IDX_LEVEL: rd_byte = {4'h0, match_irq_level, wrap_irq_level};
            `LT_IDX_FLAGS: rd_byte = {6'h00, match_flag_reg, wrap_flag_reg};
            5'h04: rd_byte = snapshot_reg[7:0]; // [R22] [R21]
            5'h05: rd_byte = snapshot_reg[15:8];
            5'h06: rd_byte = snapshot_reg[23:16];
            5'h07: rd_byte = snapshot_reg[31:24];
            5'h08: rd_byte = cycle_limit_reg[7:0];
            5'h09: rd_byte = cycle_limit_reg[15:8];
            5'h0A: rd_byte = cycle_limit_reg[23:16];
            5'h0B: rd_byte = cycle_limit_reg[31:24];
            5'h0C: rd_byte = match_value_reg[7:0];
            5'h0D: rd_byte = match_value_reg[15:8];
            5'h0E: rd_byte = match_value_reg[23:16];
            5'h0F: rd_byte = match_value_reg[31:24];
            `LT_IDX_CLKSEL: rd_byte = {7'h00, clksel_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // pin synchronisers; only the second stage is looked at
    always @(posedge aclk) begin
        if (!aresetn) begin
            khz_s1_reg <= 1'b0;
            khz_s2_reg <= 1'b0;
            hz_s1_reg <= 1'b0;
            hz_s2_reg <= 1'b0;
            slow_prev_reg <= 1'b0;
        end else begin
            khz_s1_reg <= slow_clk_khz;
            khz_s2_reg <= khz_s1_reg;
            hz_s1_reg <= slow_clk_hz;
            hz_s2_reg <= hz_s1_reg;
            slow_prev_reg <= slow_now; // [R2]
        end
    end

    // axi4-lite handshakes; one write and one read in flight at most
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LT_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `LT_RESP_OKAY;
            s_axi_rdata <= `LT_RST_WORD;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= `LT_RST_WORD;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_idx == 6'h3F) ? `LT_RESP_SLVERR : `LT_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= (rd_idx == 6'h3F) ? `LT_RESP_SLVERR : `LT_RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // register file, transfer timers and the counting core
    always @(posedge aclk) begin
        if (!aresetn) begin
            clksel_reg <= 1'b0;
            enable_sw_reg <= 1'b0; // [R23]
            enable_run_reg <= 1'b0;
            ctrl_busy_reg <= 1'b0;
            cnt_busy_reg <= 1'b0;
            cnt_timer_reg <= 4'h0;
            snap_req_reg <= 1'b0;
            snap_timer_reg <= 4'h0;
            count_value_reg <= `LT_RST_WORD;
            count_wbuf_reg <= `LT_RST_WORD;
            snapshot_reg <= `LT_RST_WORD;
            cycle_limit_reg <= `LT_RST_WORD;
            match_value_reg <= `LT_RST_WORD;
            suppress_reg <= 2'h0;
            match_flag_reg <= 1'b0;
            wrap_flag_reg <= 1'b0;
            match_evdiv_reg <= 2'h0;
            wrap_evdiv_reg <= 2'h0;
            match_irq_level <= 2'h0;
            wrap_irq_level <= 2'h0;
            match_irq_req <= 1'b0;
            wrap_irq_req <= 1'b0;
            match_event <= 1'b0;
            wrap_event <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            // enable lands on the next falling slow edge, up to one slow cycle after the write
            if (ctrl_busy_reg && slow_fall) begin
                enable_run_reg <= enable_sw_reg; // [R6]
                ctrl_busy_reg <= 1'b0; // [R10]
            end
            if (wr_byte && wr_hit(wr_idx, `LT_IDX_CTRL)) begin
                enable_sw_reg <= wb[`LT_BIT_ENABLE]; // [R6]
                ctrl_busy_reg <= 1'b1; // [R10]
            end

            if (wr_byte && wr_hit(wr_idx, `LT_IDX_LEVEL)) begin
                match_irq_level <= wb[3:2]; // [R14]
                wrap_irq_level <= wb[1:0];
            end
            if (wr_byte && wr_hit(wr_idx, `LT_IDX_CLKSEL)) begin
                clksel_reg <= wb[`LT_BIT_CLKSEL]; // [R2]
            end

            // count bytes are staged; the top byte launches the transfer
            if (wr_byte && !sync_pending_flag
                    && in_group(wr_idx, `LT_IDX_COUNT_BYTE_LOW)) begin // [R12]
                case (wr_idx[1:0])
                    2'h0: count_wbuf_reg[7:0] <= wb;
                    2'h1: count_wbuf_reg[15:8] <= wb;
                    2'h2: count_wbuf_reg[23:16] <= wb;
                    default: begin
                        count_wbuf_reg[31:24] <= wb;
                        cnt_busy_reg <= 1'b1; // [R10]
                        cnt_timer_reg <= `LT_CNT_SYNC_CYC;
                    end
                endcase
            end

            // limit only moves while stopped and idle
            if (wr_byte && !enable_sw_reg && !enable_run_reg && !sync_pending_flag
                    && in_group(wr_idx, `LT_IDX_LIM0)) begin // [R19]
                case (wr_idx[1:0])
                    2'h0: cycle_limit_reg[7:0] <= wb;
                    2'h1: cycle_limit_reg[15:8] <= wb;
                    2'h2: cycle_limit_reg[23:16] <= wb;
                    default: cycle_limit_reg[31:24] <= wb;
                endcase
            end
            if (wr_byte && in_group(wr_idx, `LT_IDX_CMP0)) begin
                case (wr_idx[1:0])
                    2'h0: match_value_reg[7:0] <= wb;
                    2'h1: match_value_reg[15:8] <= wb;
                    2'h2: match_value_reg[23:16] <= wb;
                    default: match_value_reg[31:24] <= wb;
                endcase
            end

            // snapshot copy, eight bus cycles from request to readable data
            if (snap_req_reg) begin
                if (snap_timer_reg == 4'h1) begin
                    snapshot_reg <= count_value_reg; // [R9]
                    snap_req_reg <= 1'b0; // [R8]
                end
                snap_timer_reg <= snap_timer_reg - 4'h1;
            end
            if (wr_byte && wr_hit(wr_idx, `LT_IDX_SYNC) && wb[`LT_BIT_SNAP]
                    && !snap_req_reg) begin
                snap_req_reg <= 1'b1; // [R8]
                snap_timer_reg <= `LT_SNAP_CYC;
            end

            // counting runs regardless of any sleep state
            if (cnt_load) begin
                count_value_reg <= count_wbuf_reg; // [R11]
                cnt_busy_reg <= 1'b0;
                suppress_reg <= `LT_SUPPRESS_TICKS; // [R13]
            end else if (tick) begin // [R7] [R17]
                count_value_reg <= wrap_hit ? `LT_RST_WORD : count_value_reg + 32'h00000001; // [R1] [R4]
                if (quiet) begin
                    suppress_reg <= suppress_reg - 2'h1; // [R13]
                end
            end
            if (cnt_busy_reg && cnt_timer_reg != 4'h0) begin
                cnt_timer_reg <= cnt_timer_reg - 4'h1;
            end

            // set beats clear in the same cycle
            if (match_set) begin
                match_flag_reg <= 1'b1; // [R15] [R3] [R20]
            end else if (match_irq_ack || (wr_byte && wr_hit(wr_idx, `LT_IDX_FLAGS)
                    && wb[`LT_BIT_MATCH])) begin
                match_flag_reg <= 1'b0; // [R15]
            end
            if (wrap_set) begin
                wrap_flag_reg <= 1'b1; // [R16] [R4]
            end else if (wrap_irq_ack || (wr_byte && wr_hit(wr_idx, `LT_IDX_FLAGS)
                    && wb[`LT_BIT_WRAP])) begin
                wrap_flag_reg <= 1'b0; // [R16]
            end
            match_irq_req <= match_flag_reg && (match_irq_level != 2'h0); // [R14]
            wrap_irq_req <= wrap_flag_reg && (wrap_irq_level != 2'h0); // [R14]

            // events are one-cycle pulses, thinned for tiny limits
            match_event <= 1'b0;
            wrap_event <= 1'b0;
            if (match_hit) begin
                if (match_evdiv_reg + 2'h1 >= ev_mod) begin
                    match_event <= 1'b1; // [R3] [R5] [R20]
                    match_evdiv_reg <= 2'h0;
                end else begin
                    match_evdiv_reg <= match_evdiv_reg + 2'h1;
                end
            end
            if (wrap_hit) begin
                if (wrap_evdiv_reg + 2'h1 >= ev_mod) begin
                    wrap_event <= 1'b1; // [R4] [R5]
                    wrap_evdiv_reg <= 2'h0;
                end else begin
                    wrap_evdiv_reg <= wrap_evdiv_reg + 2'h1;
                end
            end
            wake_req <= match_set || wrap_set; // [R17] [R13]
        end
    end

endmodule

// ---- tb/lt_timekeeper_props.sv ----
/* port checker for lt_timekeeper.
   assumes every port is synchronous to aclk and aresetn is active low. */
`timescale 1ns/10ps
module lt_timekeeper_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire wrap_irq_ack,
    input wire match_irq_req,
    input wire wrap_irq_req,
    input wire [1:0] match_irq_level,
    input wire [1:0] wrap_irq_level,
    input wire match_event,
    input wire wrap_event,
    input wire wake_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_IDLE: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus not idle after reset");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_B_AFTER_BOTH: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_WRAP_REQ_LVL: assert property (wrap_irq_req |-> wrap_irq_level != 2'h0)
        else $error("wrap request while disabled");
    AST_MATCH_REQ_LVL: assert property (match_irq_req |-> match_irq_level != 2'h0)
        else $error("match request while disabled");
    AST_LVL_BY_WRITE: assert property (!$stable(wrap_irq_level) || !$stable(match_irq_level) |-> s_axi_bvalid)
        else $error("level changed without a write");
    AST_WAKE_PULSE: assert property (wake_req |=> !wake_req)
        else $error("wake held too long");
    AST_EVT_PULSE: assert property (wrap_event || match_event |=> !wrap_event && !match_event)
        else $error("event held too long");
    AST_WRAP_ACK: assert property (wrap_irq_ack && wrap_irq_req |-> ##[1:3] !wrap_irq_req)
        else $error("ack did not clear wrap request");
endmodule
bind lt_timekeeper lt_timekeeper_props lt_timekeeper_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .wrap_irq_ack, .match_irq_req, .wrap_irq_req, .match_irq_level,
    .wrap_irq_level, .match_event, .wrap_event, .wake_req);

// ---- tb/lt_timekeeper_tb.sv ----
/* register-level bench for lt_timekeeper.
   assumes slow clock pins may run far faster than the crystal rates. */
`timescale 1ns/10ps
module lt_timekeeper_tb;
    reg aclk = 1'h0, aresetn = 1'h0, slow_clk_khz = 1'h0, slow_clk_hz = 1'h0, khz_run = 1'h1;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, match_irq_ack = 1'h0, wrap_irq_ack = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rd;
    reg [31:0] s_axi_wdata = 32'h00000000;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg [1:0] rsp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, match_irq_level, wrap_irq_level;
    wire [31:0] s_axi_rdata;
    wire match_irq_req, wrap_irq_req, match_event, wrap_event, wake_req;
    integer n_errors = 0, check_count = 0, cyc = 0, i, n_wake = 0, n_wrap_ev = 0, n_match_ev = 0, w0, e0, m0;
    lt_timekeeper lt_timekeeper_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .slow_clk_khz, .slow_clk_hz, .match_irq_ack, .wrap_irq_ack, .match_irq_req,
        .wrap_irq_req, .match_irq_level, .wrap_irq_level, .match_event, .wrap_event, .wake_req);
    always #2 aclk = ~aclk;
    // slow ticks every 50 cycles keep wrap periods short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (khz_run && cyc % 25 == 24) slow_clk_khz <= ~slow_clk_khz;
        if (wake_req) n_wake <= n_wake + 1;
        if (wrap_event) n_wrap_ev <= n_wrap_ev + 1;
        if (match_event) n_match_ev <= n_match_ev + 1;
        if (cyc % 90 == 89) slow_clk_hz <= ~slow_clk_hz;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    task final_report;
        begin
            $display("checks %0d errors %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [4:0] idx, input [7:0] d);
        integer n;
        begin
            n = 0;
            s_axi_awaddr <= {1'h0, idx, 2'h0};
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
                n = n + 1;
            end while (!s_axi_bvalid && n < 40);
            rsp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            if (n >= 40) n_errors = n_errors + 1;
            @(posedge aclk);
        end
    endtask
    task rdr(input [4:0] idx);
        integer n;
        begin
            n = 0;
            s_axi_araddr <= {1'h0, idx, 2'h0};
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
                n = n + 1;
            end while (!s_axi_rvalid && n < 40);
            rd = s_axi_rdata[7:0];
            rsp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            if (n >= 40) n_errors = n_errors + 1;
            @(posedge aclk);
        end
    endtask
    task rchk(input [4:0] idx, input [7:0] exp);
        begin
            rdr(idx);
            chk(rd, exp);
        end
    endtask
    // limit and count writes are refused while a transfer is pending
    task idle;
        integer n;
        begin
            n = 0;
            do begin
                rdr(1);
                n = n + 1;
            end while (rd[0] && n < 100);
            chk(rd[0], 1'h0);
        end
    endtask
    task snap;
        begin
            wr(1, 8'h10);
            repeat (8) @(posedge aclk);
            rchk(1, 8'h00);
        end
    endtask
    task wait_wrap;
        integer n;
        begin
            n = 0;
            while (wrap_irq_req !== 1'h1 && n < 1000) begin
                @(posedge aclk);
                n = n + 1;
            end
            chk(wrap_irq_req, 1'h1);
        end
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 17; i = i + 1) rchk(i[4:0], 8'h00);
        rdr(5'h11);
        chk(rsp, 2'h2);
        wr(5'h1F, 8'hFF);
        chk(rsp, 2'h2);
        wr(2, 8'h0D);
        chk({match_irq_level, wrap_irq_level}, 4'hD);
        s_axi_wstrb <= 4'h0;
        wr(2, 8'h00);
        s_axi_wstrb <= 4'hF;
        rchk(2, 8'h0D);
        wr(0, 8'h01);
        repeat (200) @(posedge aclk);
        snap;
        rchk(4, 8'h00);
        wr(0, 8'h00);
        idle;
        wr(8, 8'h05);
        wr(5'h0C, 8'h02);
        rchk(8, 8'h05);
        wr(0, 8'h01);
        wait_wrap;
        chk(match_irq_req, 1'h1);
        rchk(3, 8'h03);
        wr(8, 8'h09);
        rchk(8, 8'h05);
        snap;
        rdr(4);
        chk(rd <= 8'h05, 1'h1);
        rchk(7, 8'h00);
        wr(3, 8'h02);
        rchk(3, 8'h01);
        chk(match_irq_req, 1'h0);
        wrap_irq_ack <= 1'h1;
        @(posedge aclk);
        wrap_irq_ack <= 1'h0;
        repeat (3) @(posedge aclk);
        chk(wrap_irq_req, 1'h0);
        rchk(3, 8'h00);
        wr(0, 8'h00);
        idle;
        wr(5'h0C, 8'h07);
        wr(0, 8'h01);
        wait_wrap;
        repeat (350) @(posedge aclk);
        rchk(3, 8'h01);
        // time the write just after a slow rising edge so the wait is long
        @(posedge slow_clk_khz);
        @(posedge aclk);
        wr(0, 8'h01);
        rchk(1, 8'h01);
        idle;
        wr(4, 8'h03);
        wr(7, 8'h01);
        repeat (12) @(posedge aclk);
        idle;
        snap;
        rchk(7, 8'h01);
        wr(3, 8'h03);
        wr(4, 8'h05);
        wr(7, 8'h00);
        repeat (55) @(posedge aclk);
        rchk(3, 8'h00);
        // limit one: events on every second wrap, first two ticks after the load stay quiet
        wr(0, 8'h00);
        idle;
        wr(8, 8'h01);
        wr(5'h0C, 8'h01);
        wr(4, 8'h00);
        wr(7, 8'h00);
        idle;
        w0 = n_wake;
        e0 = n_wrap_ev;
        m0 = n_match_ev;
        wr(0, 8'h01);
        for (i = 0; i < 2000 && n_wake < w0 + 3; i = i + 1) @(posedge aclk);
        chk(n_wake - w0, 3);
        chk(n_wrap_ev - e0, 2);
        chk(n_match_ev - m0, 2);
        // second clock pin alone must keep the counter going
        wr(5'h10, 8'h01);
        rchk(5'h10, 8'h01);
        khz_run <= 1'h0;
        w0 = n_wake;
        for (i = 0; i < 2000 && n_wake < w0 + 2; i = i + 1) @(posedge aclk);
        chk(n_wake - w0, 2);
        final_report;
    end
endmodule
